// ---- rtl/ebc_defines.vh ----
// constants shared by the external bus control block
`ifndef EBC_DEFINES_VH
`define EBC_DEFINES_VH

`define EBC_MODE_SINGLE  2'h0
`define EBC_MODE_EXPAND  2'h1
`define EBC_MODE_MICRO   2'h3

`define EBC_SP_INT       2'h0
`define EBC_SP_SFR       2'h1
`define EBC_SP_EXT       2'h2

`define EBC_BM_SEP       2'h0
`define EBC_BM_MUX_CS2   2'h1
`define EBC_BM_MUX_CS1   2'h2
`define EBC_BM_MUX_ALL   2'h3

`define EBC_CSC_NONE     2'h0
`define EBC_CSC_ONE      2'h1
`define EBC_CSC_TWO      2'h2
`define EBC_CSC_FOUR     2'h3

`define EBC_LATCH_NONE   2'h0

`define EBC_LEN_INT      4'h1
`define EBC_LEN_INT_W    4'h2
`define EBC_LEN_SFR      4'h2
`define EBC_LEN_SFR_W    4'h3
`define EBC_LEN_EXT_DEF  4'h2

`define EBC_CS_IDLE      4'hF
`define EBC_DS_RESET     4'h0
`define EBC_DS_STRAP_BIT 3
`define EBC_TOP_BIT      23
`define EBC_MUX64_HI     8'h00
`define EBC_PH_ADDR      4'h0
`define EBC_CNT_ONE      4'h1
`define EBC_INIT_DONE    2'h3
`define EBC_INIT_STEP    2'h1

`endif

// ---- rtl/ebc_sync.v ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ebc_sync #(
   parameter W = 1
) (
   input  wire         ref_clk,
   input  wire         resetn,
   input  wire [W-1:0] pin_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else
      begin
         meta_q <= pin_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // ebc_sync
`default_nettype wire

// ---- rtl/ebc_cycle_len.v ----
// bus cycle length in bus clocks for one access
`timescale 1ns/1ps
`default_nettype none
`include "ebc_defines.vh"
module ebc_cycle_len (
   input  wire [1:0] space,
   input  wire       internal_wait_en,
   input  wire       sfr_wait_en,
   input  wire [4:0] ext_cycle_field,
   input  wire       mux_bus,
   output reg  [3:0] len
);
   always @*
   begin
      len = `EBC_LEN_EXT_DEF;
      case (space)
         `EBC_SP_INT: len = internal_wait_en ? `EBC_LEN_INT_W
                                             : `EBC_LEN_INT;
         `EBC_SP_SFR: len = sfr_wait_en ? `EBC_LEN_SFR_W
                                        : `EBC_LEN_SFR;
         default:
         begin
            // reserved codes fall back to the basic two-clock cycle
            if (!mux_bus)
            begin
               case (ext_cycle_field)
                  5'h01: len = 4'h2;
                  5'h02: len = 4'h3;
                  5'h03: len = 4'h4;
                  5'h04: len = 4'h5;
                  5'h05: len = 4'h6;
                  5'h06: len = 4'h7;
                  5'h0A: len = 4'h4;
                  5'h0B: len = 4'h5;
                  5'h0C: len = 4'h6;
                  5'h13: len = 4'h6;
                  5'h14: len = 4'h7;
                  5'h16: len = 4'h9;
                  default: len = `EBC_LEN_EXT_DEF;
               endcase
            end
            else
            begin
               case (ext_cycle_field)
                  5'h0A: len = 4'h4;
                  5'h0B: len = 4'h5;
                  5'h0D: len = 4'h7;
                  5'h13: len = 4'h6;
                  5'h14: len = 4'h7;
                  5'h15: len = 4'h8;
                  5'h16: len = 4'h9;
                  default: len = `EBC_LEN_EXT_DEF;
               endcase
            end
         end
      endcase
   end
endmodule // ebc_cycle_len
`default_nettype wire

// ---- rtl/ebc_top.v ----
// external bus control: address, chip selects, strobes, cycle timing
//
// Function
// - all-multiplexed in expansion mode: 64-Kbyte area per chip select
// - latch selector none holds latch pin low, not a port
// - bus signals only in expansion or microprocessor mode; external cycle length counts in every mode
// - 24 address outputs, top bit driven inverted while no chip select is configured
// - width register picks 8- or 16-bit bus per external space
// - space 3 width follows strap at reset: high 8-bit, low 16-bit
// - address may be undefined after mode switch until first external access
// - chip selects share upper address pins, two-bit field sets up to four
// - after reset no chip select except the inverted top address bit
// - chip select low while its area accessed, high for other space
// - new area changes address and selects, same area only address
// - internal after external: select changes, address held; idle holds
// - 16-bit bus: scheme bit picks byte-enable or split write strobes
// - 8-bit space access always uses the byte-enable scheme
// - after reset byte-enable scheme is in use
// - split strobes: low writes even, high writes odd, both word
// - byte enable with A0 picks odd, even or word; unused on 8-bit
// - internal 1 or 2 clocks, special registers 2 or 3 clocks
// - four five-bit cycle fields: twelve separate, seven multiplexed codes
// - cycle field codes map to listed bus clock counts
`timescale 1ns/1ps
`default_nettype none
`include "ebc_defines.vh"
module ebc_top (
   input  wire        ref_clk,
   input  wire        resetn,
   input  wire [1:0]  proc_mode,
   input  wire        bus_mode_hi,
   input  wire        bus_mode_lo,
   input  wire        latch_pin_sel_hi,
   input  wire        latch_pin_sel_lo,
   input  wire        strobe_scheme_sel,
   input  wire        cs_config_hi,
   input  wire        cs_config_lo,
   input  wire        internal_wait_en,
   input  wire        sfr_wait_en,
   input  wire [4:0]  ext_cycle_field0,
   input  wire [4:0]  ext_cycle_field1,
   input  wire [4:0]  ext_cycle_field2,
   input  wire [4:0]  ext_cycle_field3,
   input  wire        width_wr,
   input  wire [3:0]  width_wdata,
   input  wire        bclk_pin,
   input  wire        byte_strap_pin,
   input  wire        req_valid,
   input  wire [1:0]  req_space,
   input  wire [1:0]  req_ext_idx,
   input  wire [23:0] req_addr,
   input  wire        req_write,
   input  wire        req_lo,
   input  wire        req_hi,
   input  wire [15:0] req_wdata,
   input  wire [15:0] d_in,
   output wire        req_ready,
   output wire        req_done,
   output wire [15:0] req_rdata,
   output wire [3:0]  bus_width_select,
   output wire [19:0] addr_lo,
   output wire [3:0]  addr_cs_pin,
   output wire        rd_n,
   output wire        write_low_strobe_n,
   output wire        write_high_strobe_n,
   output wire        latch_pin,
   output wire        latch_pin_oe_n,
   output wire        bus_oe_n,
   output wire [15:0] d_out,
   output wire        d_oe_n
);
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   // shared upper address pins: pin 0 is the lowest one, chip select 0 drives the highest
   function [3:0] pin_map;
      input [1:0]  cfg;
      input [23:0] a;
      input [3:0]  cs;
      begin
         case (cfg)
            `EBC_CSC_NONE: pin_map = {~a[`EBC_TOP_BIT], a[22:20]};
            `EBC_CSC_ONE:  pin_map = {cs[0], a[22:20]};
            `EBC_CSC_TWO:  pin_map = {cs[0], cs[1], a[21:20]};
            default:       pin_map = {cs[0], cs[1], cs[2], cs[3]};
         endcase
      end
   endfunction

   function is_mux;
      input [1:0] bm;
      input [1:0] mode;
      input [1:0] idx;
      begin
         case (bm)
            `EBC_BM_MUX_ALL: is_mux = (mode == `EBC_MODE_EXPAND);
            `EBC_BM_MUX_CS2: is_mux = (idx == 2'h2);
            `EBC_BM_MUX_CS1: is_mux = (idx == 2'h1);
            default:         is_mux = 1'b0;
         endcase
      end
   endfunction

   wire [17:0] sync_w;
   wire        bclk_s   = sync_w[17];
   wire        strap_s  = sync_w[16];
   wire [15:0] d_s      = sync_w[15:0];
   ebc_sync #(.W(18)) u_sync (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .pin_in   ({bclk_pin, byte_strap_pin, d_in}),
      .sync_out (sync_w)
   );

   wire [1:0] bm_w    = {bus_mode_hi, bus_mode_lo};
   wire [1:0] lsel_w  = {latch_pin_sel_hi, latch_pin_sel_lo};
   wire [1:0] csc_w   = {cs_config_hi, cs_config_lo};
   wire       bus_act = (proc_mode == `EBC_MODE_EXPAND) ||
                        (proc_mode == `EBC_MODE_MICRO);
   wire       mux_w   = is_mux(bm_w, proc_mode, req_ext_idx);
   reg  [4:0] field_w;
   wire [3:0] len_w;

   always @*
   begin
      case (req_ext_idx)
         2'h0:    field_w = ext_cycle_field0;
         2'h1:    field_w = ext_cycle_field1;
         2'h2:    field_w = ext_cycle_field2;
         default: field_w = ext_cycle_field3;
      endcase
   end

   ebc_cycle_len u_len (
      .space            (req_space),
      .internal_wait_en (internal_wait_en),
      .sfr_wait_en      (sfr_wait_en),
      .ext_cycle_field  (field_w),
      .mux_bus          (mux_w),
      .len              (len_w)
   );

   reg        st_q;
   reg        bclk_prev_q;
   reg [1:0]  init_q;
   reg [3:0]  ds_q;
   reg [3:0]  len_q;
   reg [3:0]  bcnt_q;
   reg        ext_q;
   reg        write_q;
   reg        lo_q;
   reg        hi_q;
   reg        wide_q;
   reg        mux_q;
   reg        sep_q;
   reg [15:0] wdata_q;
   reg [23:0] addr_q;
   reg [3:0]  cs_q;
   reg [3:0]  pin_q;
   reg        ready_q;
   reg        done_q;
   reg [15:0] rdata_q;
   reg        rd_n_q;
   reg        wrl_n_q;
   reg        wrh_n_q;
   reg        latch_q;
   reg        latch_oe_n_q;
   reg        bus_oe_n_q;
   reg [15:0] dout_q;
   reg        doe_n_q;

   wire bclk_rise = bclk_s & ~bclk_prev_q;
   wire take      = (st_q == ST_IDLE) && req_valid && bclk_rise;
   wire take_ext  = take && (req_space == `EBC_SP_EXT) && bus_act;
   wire last      = (st_q == ST_RUN) && bclk_rise &&
                    (bcnt_q == len_q - `EBC_CNT_ONE);
   wire wide_w    = ds_q[req_ext_idx];

   reg [23:0] addr_d;
   reg [3:0]  cs_d;
   reg        a0_w;

   always @*
   begin
      addr_d = addr_q;
      cs_d   = cs_q;
      // a half-word lane request sets A0 itself on a wide bus
      a0_w   = wide_w ? (req_hi & ~req_lo) : req_addr[0];
      if (take_ext)
      begin
         // address only moves on external cycles, so it stays
         // undefined after a mode switch until the first one
         addr_d = {req_addr[23:1], a0_w};
         if (is_mux(bm_w, proc_mode, req_ext_idx) &&
             bm_w == `EBC_BM_MUX_ALL)
            addr_d[23:16] = `EBC_MUX64_HI;
         cs_d = `EBC_CS_IDLE;
         cs_d[req_ext_idx] = 1'b0;
      end
      else if (take && bus_act)
         cs_d = `EBC_CS_IDLE;
   end

   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q        <= ST_IDLE;
         bclk_prev_q <= 1'b0;
         init_q      <= 2'h0;
         ds_q        <= `EBC_DS_RESET;
         len_q       <= `EBC_LEN_EXT_DEF;
         bcnt_q      <= `EBC_PH_ADDR;
         ext_q       <= 1'b0;
         write_q     <= 1'b0;
         lo_q        <= 1'b0;
         hi_q        <= 1'b0;
         wide_q      <= 1'b0;
         mux_q       <= 1'b0;
         sep_q       <= 1'b0;
         wdata_q     <= 16'h0000;
         addr_q      <= 24'h000000;
         cs_q        <= `EBC_CS_IDLE;
         ready_q     <= 1'b0;
         done_q      <= 1'b0;
         rdata_q     <= 16'h0000;
      end
      else
      begin
         bclk_prev_q <= bclk_s;
         addr_q      <= addr_d;
         cs_q        <= cs_d;
         done_q      <= last;
         // strap is caught once the synchroniser has settled
         if (init_q != `EBC_INIT_DONE)
            init_q <= init_q + `EBC_INIT_STEP;
         if (init_q == `EBC_INIT_STEP + `EBC_INIT_STEP)
            ds_q[`EBC_DS_STRAP_BIT] <= ~strap_s;
         else if (width_wr)
            ds_q <= width_wdata;
         if (take)
         begin
            st_q    <= ST_RUN;
            len_q   <= len_w;
            bcnt_q  <= `EBC_PH_ADDR;
            ext_q   <= take_ext;
            write_q <= req_write;
            lo_q    <= req_lo;
            hi_q    <= req_hi;
            wide_q  <= wide_w;
            mux_q   <= mux_w;
            // narrow spaces force the byte-enable scheme
            sep_q   <= strobe_scheme_sel & wide_w;
            wdata_q <= req_wdata;
         end
         else if (last)
         begin
            st_q <= ST_IDLE;
            if (ext_q && !write_q)
               rdata_q <= (!wide_q && hi_q && !lo_q) ?
                          {d_s[7:0], 8'h00} : d_s;
         end
         else if (st_q == ST_RUN && bclk_rise)
            bcnt_q <= bcnt_q + `EBC_CNT_ONE;
         ready_q <= (st_q == ST_IDLE) ? !take : last;
      end
   end

   wire run_ext   = (st_q == ST_RUN) && ext_q;
   wire strobe_on = run_ext && (bcnt_q != `EBC_PH_ADDR);
   wire addr_ph   = run_ext && mux_q && (bcnt_q == `EBC_PH_ADDR);
   reg         rd_n_d;
   reg         wrl_n_d;
   reg         wrh_n_d;
   reg  [15:0] dout_d;

   always @*
   begin
      rd_n_d = ~(strobe_on & ~write_q);
      if (sep_q)
      begin
         wrl_n_d = ~(strobe_on & write_q & lo_q);
         wrh_n_d = ~(strobe_on & write_q & hi_q);
      end
      else
      begin
         // after reset sep_q is clear: byte-enable scheme
         wrl_n_d = ~(strobe_on & write_q);
         wrh_n_d = wide_q ? ~(run_ext & hi_q) : 1'b1;
      end
      if (addr_ph)
         dout_d = wide_q ? addr_q[15:0] : {8'h00, addr_q[7:0]};
      else if (!wide_q && hi_q && !lo_q)
         dout_d = {8'h00, wdata_q[15:8]};
      else
         dout_d = wdata_q;
   end

   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_q        <= {1'b1, 3'h0};
         rd_n_q       <= 1'b1;
         wrl_n_q      <= 1'b1;
         wrh_n_q      <= 1'b1;
         latch_q      <= 1'b0;
         latch_oe_n_q <= 1'b1;
         bus_oe_n_q   <= 1'b1;
         dout_q       <= 16'h0000;
         doe_n_q      <= 1'b1;
      end
      else
      begin
         pin_q        <= pin_map(csc_w, addr_d, cs_d);
         rd_n_q       <= rd_n_d;
         wrl_n_q      <= wrl_n_d;
         wrh_n_q      <= wrh_n_d;
         // with no latch pin selected the pin carries no meaning
         // but is still owned by the bus, never a port
         latch_q      <= (lsel_w != `EBC_LATCH_NONE) & addr_ph;
         latch_oe_n_q <= ~bus_act;
         bus_oe_n_q   <= ~bus_act;
         dout_q       <= dout_d;
         doe_n_q      <= ~(addr_ph | (strobe_on & write_q));
      end
   end

   assign req_ready           = ready_q;
   assign req_done            = done_q;
   assign req_rdata           = rdata_q;
   assign bus_width_select    = ds_q;
   assign addr_lo             = addr_q[19:0];
   assign addr_cs_pin         = pin_q;
   assign rd_n                = rd_n_q;
   assign write_low_strobe_n  = wrl_n_q;
   assign write_high_strobe_n = wrh_n_q;
   assign latch_pin           = latch_q;
   assign latch_pin_oe_n      = latch_oe_n_q;
   assign bus_oe_n            = bus_oe_n_q;
   assign d_out               = dout_q;
   assign d_oe_n              = doe_n_q;
endmodule // ebc_top
`default_nettype wire

// ---- verif/ebc_mem_model.sv ----
// external 16-bit memory that answers the bus strobes
`timescale 1ns/1ps
`default_nettype none
module ebc_mem_model (
   input  wire logic        ref_clk,
   input  wire logic        scheme,
   input  wire logic [19:0] addr_lo,
   input  wire logic        rd_n,
   input  wire logic        wl_n,
   input  wire logic        wh_n,
   input  wire logic [15:0] d_out,
   output logic      [15:0] d_in
);
   logic [15:0] mem [0:15];
   logic [15:0] last_q = 16'h0000;
   wire  [3:0]  ix = addr_lo[4:1];
   // byte-enable scheme needs enable and A0 together to pick a lane
   wire lo_w = scheme ? !wl_n : !wl_n && !addr_lo[0];
   wire hi_w = scheme ? !wh_n : !wl_n && !wh_n;
   always @(posedge ref_clk)
   begin
      if (lo_w)
         mem[ix][7:0] <= d_out[7:0];
      if (hi_w)
         mem[ix][15:8] <= d_out[15:8];
      if (!rd_n)
         last_q <= mem[ix];
   end
   // released lines show the inverse so a late sample cannot pass
   assign d_in = rd_n ? ~last_q : mem[ix];
endmodule // ebc_mem_model
`default_nettype wire

// ---- verif/ebc_top_chk.sv ----
// port assertions for the external bus control block
`timescale 1ns/1ps
`default_nettype none
module ebc_top_chk (
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic [1:0]  proc_mode,
   input wire logic        bus_mode_hi,
   input wire logic        bus_mode_lo,
   input wire logic        cs_config_hi,
   input wire logic        cs_config_lo,
   input wire logic [1:0]  req_space,
   input wire logic [23:0] req_addr,
   input wire logic        req_ready,
   input wire logic        req_done,
   input wire logic [19:0] addr_lo,
   input wire logic [3:0]  addr_cs_pin,
   input wire logic        rd_n,
   input wire logic        write_low_strobe_n,
   input wire logic        bus_oe_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   wire         cs4 = cs_config_hi & cs_config_lo;
   logic [23:0] addr_q;
   logic [1:0]  space_q;
   // request as it stood on the taking edge
   always @(posedge ref_clk)
   begin
      addr_q <= req_addr;
      space_q <= req_space;
   end
   a_done_pulse: assert property (req_done |=> !req_done)
      else $error("done pulse too long");
   a_done_bound: assert property ($fell(req_ready)
      |-> ##[1:200] req_done)
      else $error("cycle never ended");
   a_rd_wr_excl: assert property (rd_n || write_low_strobe_n)
      else $error("read and write low together");
   a_strobe_window: assert property ((!rd_n || !write_low_strobe_n)
      |-> !req_ready || req_done || $past(req_done))
      else $error("strobe outside a cycle");
   a_single_quiet: assert property (proc_mode == 2'h0
      && $past(proc_mode) == 2'h0 && $past(proc_mode, 2) == 2'h0
      |-> bus_oe_n && rd_n && write_low_strobe_n)
      else $error("bus active in single-chip mode");
   a_cs_one_low: assert property (cs4 && $past(cs4) && $past(resetn)
      |-> $countones(~addr_cs_pin) <= 1)
      else $error("two chip selects low");
   a_int_cs_high: assert property ($fell(req_ready)
      && space_q != 2'h2 && cs4 |-> addr_cs_pin == 4'hF)
      else $error("select low on internal access");
   a_addr_follow: assert property ($fell(req_ready) && space_q == 2'h2
      && proc_mode == 2'h3 && !bus_mode_hi && !bus_mode_lo
      |-> addr_lo[19:1] == addr_q[19:1])
      else $error("address not from request");
endmodule // ebc_top_chk
`default_nettype wire

// ---- verif/ebc_top_tb_top.sv ----
// self-checking bench for the external bus control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
   begin checks++; if ((got) !== (ex)) begin fail_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module ebc_top_tb_top;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        bclk_pin = 1'b0;
   logic [1:0]  proc_mode = 2'h3;
   logic [1:0]  bus_mode = 2'h0;
   logic [1:0]  latch_sel = 2'h0;
   logic [1:0]  cs_cfg = 2'h0;
   logic        scheme = 1'b0;
   logic        int_w = 1'b0;
   logic        sfr_w = 1'b0;
   logic [4:0]  cyc [0:3] = '{5'h01, 5'h01, 5'h06, 5'h01};
   logic        width_wr = 1'b0;
   logic [3:0]  width_wdata = 4'h0;
   logic        strap = 1'b0;
   logic        req_valid = 1'b0;
   logic [1:0]  req_space = 2'h0;
   logic [1:0]  req_ext_idx = 2'h0;
   logic [23:0] req_addr = 24'h000000;
   logic        req_write = 1'b0;
   logic        req_lo = 1'b0;
   logic        req_hi = 1'b0;
   logic [15:0] req_wdata = 16'h0000;
   logic [19:0] last_a = 20'h00000;
   logic        srd, swl, swh, soe, slat, bprev;
   wire  [15:0] d_in, req_rdata, d_out;
   wire  [19:0] addr_lo;
   wire  [3:0]  bus_width_select, addr_cs_pin;
   wire         req_ready, req_done, rd_n, wl_n, wh_n, latch_pin, bus_oe_n;
   wire         d_oe_n, lat_oe_n;
   int          checks = 0;
   int          fail_count = 0;
   int          nr;
   logic [4:0]  sc [0:18] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
      5'h0A, 5'h0B, 5'h0C, 5'h13, 5'h14, 5'h16,
      5'h0A, 5'h0B, 5'h0D, 5'h13, 5'h14, 5'h15, 5'h16};
   int          sl [0:18] = '{2, 3, 4, 5, 6, 7, 4, 5, 6, 6, 7, 9,
      4, 5, 7, 6, 7, 8, 9};

   always #5 ref_clk = ~ref_clk;
   always #80 bclk_pin = ~bclk_pin;
   always @(posedge ref_clk) bprev <= bclk_pin;

   ebc_top u_dut (
      .ref_clk, .resetn, .proc_mode,
      .bus_mode_hi(bus_mode[1]), .bus_mode_lo(bus_mode[0]),
      .latch_pin_sel_hi(latch_sel[1]), .latch_pin_sel_lo(latch_sel[0]),
      .strobe_scheme_sel(scheme), .cs_config_hi(cs_cfg[1]),
      .cs_config_lo(cs_cfg[0]), .internal_wait_en(int_w),
      .sfr_wait_en(sfr_w), .ext_cycle_field0(cyc[0]),
      .ext_cycle_field1(cyc[1]), .ext_cycle_field2(cyc[2]),
      .ext_cycle_field3(cyc[3]), .width_wr, .width_wdata, .bclk_pin,
      .byte_strap_pin(strap), .req_valid, .req_space, .req_ext_idx,
      .req_addr, .req_write, .req_lo, .req_hi, .req_wdata, .d_in,
      .req_ready, .req_done, .req_rdata, .bus_width_select, .addr_lo,
      .addr_cs_pin, .rd_n, .write_low_strobe_n(wl_n),
      .write_high_strobe_n(wh_n), .latch_pin, .latch_pin_oe_n(lat_oe_n),
      .bus_oe_n, .d_out, .d_oe_n);

   ebc_mem_model u_mem (
      .ref_clk, .scheme, .addr_lo, .rd_n, .wl_n, .wh_n, .d_out, .d_in);

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic do_reset(input logic s);
      resetn <= 1'b0;
      strap <= s;
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (6) @(posedge ref_clk);
   endtask

   // one bus cycle; counts bus clock rises between take and done
   task automatic xfer(input logic [1:0] sp, ix, input logic [23:0] a,
                       input logic w, input logic [1:0] lh,
                       input logic [15:0] wd);
      int          n;
      logic        mux;
      logic [3:0]  ep;
      logic [19:0] ea;
      n = 0;
      // a mode written just before the call lands only at this edge
      @(posedge ref_clk);
      mux = proc_mode == 2'h1 && bus_mode == 2'h3;
      ep = mux ? 4'h8 : {~a[23], a[22:20]};
      ea = {mux ? 4'h0 : a[19:16], a[15:1], lh == 2'h2};
      req_valid <= 1'b1;
      req_space <= sp;
      req_ext_idx <= ix;
      req_addr <= a;
      req_write <= w;
      {req_hi, req_lo} <= lh;
      req_wdata <= wd;
      {srd, swl, swh, soe, slat} = 5'h00;
      nr = 0;
      while (req_ready !== 1'b0 && n < 300)
      begin
         @(posedge ref_clk);
         n++;
      end
      req_valid <= 1'b0;
      while (req_done !== 1'b1 && n < 600)
      begin
         @(posedge ref_clk);
         n++;
         nr += int'(bclk_pin && !bprev);
         srd |= !rd_n;
         swl |= !wl_n;
         swh |= !wh_n;
         soe |= !bus_oe_n || !d_oe_n || !lat_oe_n;
         slat |= latch_pin;
      end
      `CHK("hang", 1'b0, n >= 600)
      if (sp == 2'h2 && proc_mode != 2'h0)
      begin
         if (cs_cfg == 2'h3)
            `CHK("cs_pins", ~(4'h8 >> ix), addr_cs_pin)
         else
            `CHK("top_pins", ep, addr_cs_pin)
         if (bus_width_select[ix])
            `CHK("addr", ea, addr_lo)
         last_a = addr_lo;
      end
      else if (sp != 2'h2 && cs_cfg == 2'h3)
      begin
         `CHK("int_pins", 4'hF, addr_cs_pin)
         `CHK("int_addr", last_a, addr_lo)
      end
   endtask

   initial
   begin
      do_reset(1'b0);
      `CHK("width_rst", 4'h8, bus_width_select)
      `CHK("pins_rst", 4'h8, addr_cs_pin)
      width_wr <= 1'b1;
      width_wdata <= 4'hD;
      @(posedge ref_clk);
      width_wr <= 1'b0;
      cs_cfg <= 2'h3;
      repeat (2) @(posedge ref_clk);
      `CHK("width", 4'hD, bus_width_select)
      for (int s = 0; s < 2; s++)
      begin
         scheme <= s[0];
         xfer(2'h2, {s[0], 1'b0}, 24'h10 << s, 1'b1, 2'h3, 16'h1234);
         xfer(2'h2, {s[0], 1'b0}, 24'h10 << s, 1'b1, 2'h1, 16'hFFAB);
         xfer(2'h2, {s[0], 1'b0}, 24'h10 << s, 1'b0, 2'h3, 16'h0000);
         `CHK("rd_lo", 16'h12AB, req_rdata)
         xfer(2'h2, {s[0], 1'b0}, 24'h10 << s, 1'b1, 2'h2, 16'hCDFF);
         xfer(2'h2, {s[0], 1'b0}, 24'h10 << s, 1'b0, 2'h3, 16'h0000);
         `CHK("rd_hi", 16'hCDAB, req_rdata)
      end
      for (int k = 0; k < 4; k++)
      begin
         int_w <= k[0];
         sfr_w <= k[0];
         xfer({1'b0, k[1]}, 2'h0, 24'h000000, 1'b0, 2'h3, 16'h0000);
         `CHK("int_len", 1 + k[1] + k[0], nr)
      end
      cs_cfg <= 2'h0;
      xfer(2'h2, 2'h3, 24'hA51234, 1'b1, 2'h3, 16'h0000);
      xfer(2'h2, 2'h1, 24'h000031, 1'b1, 2'h2, 16'h5A00);
      `CHK("byte_wr", 1'b1, swl)
      xfer(2'h2, 2'h1, 24'h000031, 1'b0, 2'h2, 16'h0000);
      `CHK("byte_rd", 16'h5A00, req_rdata)
      cs_cfg <= 2'h3;
      for (int i = 0; i < 19; i++)
      begin
         if (i == 12)
         begin
            proc_mode <= 2'h1;
            bus_mode <= 2'h3;
            cs_cfg <= 2'h0;
            latch_sel <= 2'h1;
         end
         cyc[0] <= sc[i];
         xfer(2'h2, 2'h0, 24'hABCDE4, 1'b1, 2'h3, 16'h0F0F);
         `CHK("ext_len", sl[i], nr)
      end
      `CHK("latch", 1'b1, slat)
      latch_sel <= 2'h0;
      xfer(2'h2, 2'h0, 24'h000040, 1'b1, 2'h3, 16'h0000);
      `CHK("latch_none", 1'b0, slat)
      // every space turns narrow at the final reset
      scheme <= 1'b0;
      proc_mode <= 2'h0;
      bus_mode <= 2'h0;
      xfer(2'h2, 2'h0, 24'h000040, 1'b1, 2'h3, 16'h0000);
      `CHK("quiet", 4'h0, {srd, swl, swh, soe})
      do_reset(1'b1);
      `CHK("width_strap", 4'h0, bus_width_select)
      wrap_up;
   end

   // whole run is near 40 us; this cuts a hang short
   initial
   begin
      #300000;
      fail_count++;
      wrap_up;
   end
endmodule // ebc_top_tb_top

bind ebc_top ebc_top_chk u_chk (
   .ref_clk, .resetn, .proc_mode, .bus_mode_hi, .bus_mode_lo,
   .cs_config_hi, .cs_config_lo, .req_space, .req_addr, .req_ready,
   .req_done, .addr_lo, .addr_cs_pin, .rd_n, .write_low_strobe_n,
   .bus_oe_n);
`default_nettype wire
